// file: include/adcr_consts.vh
`ifndef ADCR_CONSTS_VH
`define ADCR_CONSTS_VH

// Register offsets
`define ADCR_OFS_CTRL_B 8'h03
`define ADCR_OFS_RES_LO 8'h04
`define ADCR_OFS_RES_HI 8'h05
`define ADCR_OFS_CTRL_A 8'h06
`define ADCR_OFS_MUX 8'h07

// Reset values
`define ADCR_RST_BYTE 8'h00
`define ADCR_RST_RES 10'h000

// converter_control_a fields
`define ADCR_A_EN 7
`define ADCR_A_SC 6
`define ADCR_A_ATE 5
`define ADCR_A_IF 4
`define ADCR_A_IE 3
`define ADCR_A_PS 2:0

// input_multiplexer_select fields
`define ADCR_M_REF_HI 7:6
`define ADCR_M_ALIGN 5
`define ADCR_M_REF_LO 4
`define ADCR_M_CHAN 3:0

// converter_control_b fields
`define ADCR_B_BIN 7
`define ADCR_B_CME 6
`define ADCR_B_IPR 5
`define ADCR_B_TS 2:0

// Conversion lengths in converter clock cycles
`define ADCR_LEN_FIRST 5'd25
`define ADCR_LEN_NORM 5'd13

// Trigger source code for free running
`define ADCR_TS_FREE 3'h0

// Channel codes
`define ADCR_CH_DIFF_LO 4'h4
`define ADCR_CH_DIFF_HI 4'hb
`define ADCR_CH_BG 4'hc
`define ADCR_CH_GND 4'hd
`define ADCR_CH_TEMP 4'hf

// Front-end input selector codes for the four pins and the internal sources
`define ADCR_SEL_TEMP 3'h4
`define ADCR_SEL_BG 3'h5
`define ADCR_SEL_GND 3'h6
`define ADCR_SEL_NONE 3'h7
`define ADCR_SEL_PIN0 3'h0
`define ADCR_SEL_PIN2 3'h2
`define ADCR_SEL_PIN3 3'h3
`define ADCR_SEL_PIN1 3'h1

// Saturated unipolar code and zero padding
`define ADCR_SAT 10'h3ff
`define ADCR_PAD6 6'h00

`endif

// file: hdl/adcr_clk_div.v
`include "adcr_consts.vh"

module adcr_clk_div #(
  parameter W = 7
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Control
  input wire run,
  input wire [2:0] sel,
  // Converter clock enable
  output reg tick
);

  reg [W-1:0] cnt_reg;
  wire [2:0] shift = (sel == 3'h0) ? 3'h1 : sel;
  wire [W:0] div = {{W{1'b0}}, 1'b1} << shift;
  wire [W-1:0] last = div[W-1:0] - {{(W-1){1'b0}}, 1'b1};

  // Restarting on idle keeps the first converter cycle a full period long
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_reg <= {W{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= {W{1'b0}};
      tick <= 1'b0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

endmodule

// file: hdl/adcr_top.v
`include "adcr_consts.vh"

module adcr_top #(
  parameter DIV_W = 7
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  // Interrupt handshake with the core
  input wire global_irq_enable,
  input wire irq_ack,
  output wire irq_req,
  // Auto-trigger sources, bit n is trigger code n
  input wire [6:1] trig_in,
  // Analog front end
  input wire [9:0] ana_value,
  input wire ana_negative,
  output wire ana_power,
  output wire ana_busy,
  output wire ana_init,
  output wire [2:0] ana_pos_sel,
  output wire [2:0] ana_neg_sel,
  output wire ana_diff,
  output wire ana_gain20,
  output wire ana_offset_cal,
  output wire [2:0] ana_ref_sel,
  output wire ana_bipolar,
  output wire ana_cmp_mux_en,
  output wire ana_pol_rev
);

  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [7:0] ctrl_b_reg;
  reg [7:0] mux_reg;
  reg en_reg, start_reg, ate_reg, flag_reg, ie_reg;
  reg [2:0] ps_reg;
  reg [9:0] result_reg;
  reg lock_reg, first_reg, irq_reg;
  reg [7:0] rdata_reg;
  reg [2:0] state_reg;
  reg [4:0] cnt_reg, len_reg;
  reg [3:0] chan_reg;
  reg [2:0] ref_reg;
  reg bin_reg;
  reg [6:1] sync1_reg, sync2_reg, sync3_reg, trig_reg;
  reg trig_prev_reg;

  wire tick;
  wire wr_a = reg_wr && (reg_addr == `ADCR_OFS_CTRL_A);
  wire wr_b = reg_wr && (reg_addr == `ADCR_OFS_CTRL_B);
  wire wr_m = reg_wr && (reg_addr == `ADCR_OFS_MUX);
  wire rd_lo = reg_rd && (reg_addr == `ADCR_OFS_RES_LO);
  wire rd_hi = reg_rd && (reg_addr == `ADCR_OFS_RES_HI);
  wire en_next = wr_a ? reg_wdata[`ADCR_A_EN] : en_reg;
  wire [2:0] ref_cur = {mux_reg[`ADCR_M_REF_HI], mux_reg[`ADCR_M_REF_LO]};
  wire [2:0] ref_new = {reg_wdata[`ADCR_M_REF_HI], reg_wdata[`ADCR_M_REF_LO]};
  wire align = mux_reg[`ADCR_M_ALIGN];
  wire [2:0] ts = ctrl_b_reg[`ADCR_B_TS];
  wire conv_end = (state_reg == ST_RUN) && tick && (cnt_reg == len_reg - 5'd1);

  adcr_clk_div #(
    .W(DIV_W)
  ) u_div (
    .mclk(mclk),
    .reset(reset),
    .run(state_reg == ST_RUN),
    .sel(ps_reg),
    .tick(tick)
  );

  // Trigger inputs come from other blocks' clocking, so three stages and agreement
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      sync3_reg <= 6'h00;
      trig_reg <= 6'h00;
    end else begin
      sync1_reg <= trig_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      trig_reg <= (sync2_reg & sync3_reg) | (trig_reg & (sync2_reg | sync3_reg));
    end
  end

  // Free running has no external edge: changing to it never fires by itself
  reg trig_level;
  always @* begin
    trig_level = 1'b0;
    if (ts != `ADCR_TS_FREE && ts != 3'h7)
      trig_level = trig_reg[ts];
  end
  wire trig_edge = trig_level && !trig_prev_reg;
  wire auto_start = ate_reg && en_reg && ((trig_edge && ts != `ADCR_TS_FREE) ||
                    (conv_end && ts == `ADCR_TS_FREE));

  // Formatting of the raw front-end value into the stored code
  reg [9:0] code;
  reg [8:0] mag;
  wire chan_diff = (chan_reg >= `ADCR_CH_DIFF_LO) && (chan_reg <= `ADCR_CH_DIFF_HI);
  always @* begin
    mag = ana_value[9:1];
    code = ana_value;
    if (chan_diff && bin_reg) begin
      if (ana_negative)
        code = ~{1'b0, mag} + 10'h001;
      else
        code = {1'b0, mag};
    end else if (chan_diff && ana_negative) begin
      code = `ADCR_SAT;
    end
  end

  // Control registers and conversion sequencing
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_b_reg <= `ADCR_RST_BYTE;
      mux_reg <= `ADCR_RST_BYTE;
      en_reg <= 1'b0;
      start_reg <= 1'b0;
      ate_reg <= 1'b0;
      flag_reg <= 1'b0;
      ie_reg <= 1'b0;
      ps_reg <= 3'h0;
      result_reg <= `ADCR_RST_RES;
      lock_reg <= 1'b0;
      first_reg <= 1'b0;
      irq_reg <= 1'b0;
      state_reg <= ST_IDLE;
      cnt_reg <= 5'd0;
      len_reg <= `ADCR_LEN_NORM;
      chan_reg <= 4'h0;
      ref_reg <= 3'h0;
      bin_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_level;
      if (wr_b)
        ctrl_b_reg <= {reg_wdata[7:5], 2'b00, reg_wdata[2:0]};
      if (wr_m)
        mux_reg <= reg_wdata;
      if (wr_a) begin
        en_reg <= reg_wdata[`ADCR_A_EN];
        ate_reg <= reg_wdata[`ADCR_A_ATE];
        ie_reg <= reg_wdata[`ADCR_A_IE];
        ps_reg <= reg_wdata[`ADCR_A_PS];
      end

      // Result pair lock across the two byte reads
      if (rd_lo)
        lock_reg <= 1'b1;
      else if (rd_hi)
        lock_reg <= 1'b0;

      case (state_reg)
        ST_IDLE: begin
          if (start_reg && en_reg) begin
            state_reg <= ST_RUN;
            cnt_reg <= 5'd0;
            chan_reg <= mux_reg[`ADCR_M_CHAN];
            ref_reg <= ref_cur;
            bin_reg <= ctrl_b_reg[`ADCR_B_BIN];
            len_reg <= first_reg ? `ADCR_LEN_FIRST : `ADCR_LEN_NORM;
            first_reg <= 1'b0;
          end
        end
        ST_RUN: begin
          if (tick)
            cnt_reg <= cnt_reg + 5'd1;
          if (conv_end)
            state_reg <= ST_DONE;
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase

      // A locked pair drops the new result but still reports completion
      if (conv_end && !lock_reg && !rd_hi)
        result_reg <= code;
      else if (conv_end && rd_hi)
        result_reg <= code;

      // Start bit: set by write of one or trigger, cleared on completion
      if (conv_end)
        start_reg <= 1'b0;
      if ((wr_a && reg_wdata[`ADCR_A_SC] && en_next) || auto_start)
        start_reg <= 1'b1;

      // Long first conversion after enabling or a reference change
      if ((wr_a && reg_wdata[`ADCR_A_EN] && !en_reg) || (wr_m && ref_new != ref_cur))
        first_reg <= 1'b1;

      // Disabling aborts everything in flight
      if (wr_a && !reg_wdata[`ADCR_A_EN]) begin
        state_reg <= ST_IDLE;
        start_reg <= 1'b0;
      end

      // Done flag: the set wins over a clear in the same cycle
      if (conv_end)
        flag_reg <= 1'b1;
      else if (irq_ack || (wr_a && reg_wdata[`ADCR_A_IF]))
        flag_reg <= 1'b0;

      irq_reg <= flag_reg && ie_reg && global_irq_enable && !irq_ack;
    end
  end

  // Read data, one cycle after the read strobe
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_reg <= `ADCR_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADCR_OFS_CTRL_B: rdata_reg <= ctrl_b_reg;
        `ADCR_OFS_MUX: rdata_reg <= mux_reg;
        `ADCR_OFS_CTRL_A: rdata_reg <= {en_reg, start_reg, ate_reg, flag_reg,
                                        ie_reg, ps_reg};
        `ADCR_OFS_RES_LO: rdata_reg <= align ? {result_reg[1:0], `ADCR_PAD6}
                                             : result_reg[7:0];
        `ADCR_OFS_RES_HI: rdata_reg <= align ? result_reg[9:2]
                                             : {`ADCR_PAD6, result_reg[9:8]};
        default: rdata_reg <= `ADCR_RST_BYTE;
      endcase
    end else begin
      rdata_reg <= `ADCR_RST_BYTE;
    end
  end

  // Front-end selection decode from the latched channel
  reg [2:0] pos_d, neg_d;
  always @* begin
    pos_d = `ADCR_SEL_NONE;
    neg_d = `ADCR_SEL_NONE;
    case (chan_reg)
      4'h0, 4'h1, 4'h2, 4'h3: pos_d = {1'b0, chan_reg[1:0]};
      4'h4, 4'h5: begin
        pos_d = `ADCR_SEL_PIN2;
        neg_d = `ADCR_SEL_PIN2;
      end
      4'h6, 4'h7: begin
        pos_d = `ADCR_SEL_PIN2;
        neg_d = `ADCR_SEL_PIN3;
      end
      4'h8, 4'h9: begin
        pos_d = `ADCR_SEL_PIN0;
        neg_d = `ADCR_SEL_PIN0;
      end
      4'ha, 4'hb: begin
        pos_d = `ADCR_SEL_PIN0;
        neg_d = `ADCR_SEL_PIN1;
      end
      `ADCR_CH_BG: pos_d = `ADCR_SEL_BG;
      `ADCR_CH_GND: pos_d = `ADCR_SEL_GND;
      `ADCR_CH_TEMP: pos_d = `ADCR_SEL_TEMP;
      default: pos_d = `ADCR_SEL_NONE;
    endcase
  end

  reg [2:0] pos_reg, neg_reg;
  reg diff_reg, gain_reg, ofs_reg, init_reg;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pos_reg <= `ADCR_SEL_NONE;
      neg_reg <= `ADCR_SEL_NONE;
      diff_reg <= 1'b0;
      gain_reg <= 1'b0;
      ofs_reg <= 1'b0;
      init_reg <= 1'b0;
    end else begin
      pos_reg <= pos_d;
      neg_reg <= neg_d;
      diff_reg <= chan_diff;
      gain_reg <= chan_diff && chan_reg[0];
      ofs_reg <= chan_diff && (pos_d == neg_d);
      // Drops together with busy so the init marker never outlives its conversion
      init_reg <= (state_reg == ST_RUN) && !conv_end && (len_reg == `ADCR_LEN_FIRST);
    end
  end

  reg busy_reg;
  always @(posedge mclk or posedge reset) begin
    if (reset)
      busy_reg <= 1'b0;
    else
      busy_reg <= (state_reg == ST_RUN) && !conv_end;
  end

  assign reg_rdata = rdata_reg;
  assign irq_req = irq_reg;
  assign ana_power = en_reg;
  assign ana_busy = busy_reg;
  assign ana_init = init_reg;
  assign ana_pos_sel = pos_reg;
  assign ana_neg_sel = neg_reg;
  assign ana_diff = diff_reg;
  assign ana_gain20 = gain_reg;
  assign ana_offset_cal = ofs_reg;
  assign ana_ref_sel = ref_reg;
  assign ana_bipolar = bin_reg;
  assign ana_cmp_mux_en = ctrl_b_reg[`ADCR_B_CME];
  assign ana_pol_rev = ctrl_b_reg[`ADCR_B_IPR];

endmodule

// file: dv/adcr_top_asserts.sv
module adcr_top_asserts (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Interrupt
  input wire global_irq_enable,
  input wire irq_ack,
  input wire irq_req,
  // Front end
  input wire ana_power,
  input wire ana_busy,
  input wire ana_init,
  input wire [2:0] ana_pos_sel,
  input wire [2:0] ana_neg_sel,
  input wire [2:0] ana_ref_sel,
  input wire ana_bipolar
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_go;
    reg_wr && reg_addr == 8'h06 && reg_wdata[7:6] == 2'b11 && !ana_busy;
  endsequence
  sequence s_busy3;
    ana_busy [*3];
  endsequence
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
  property p_resv; reg_rd && reg_addr == 8'h03 |=> reg_rdata[4:3] == 2'b00; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
  property p_irq_gie; irq_req |-> $past(global_irq_enable); endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("request without global enable");
  property p_irq_ack; irq_ack |=> !irq_req; endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("request after acknowledge");
  property p_start; s_go |-> ##3 ana_busy; endproperty
  a_start: assert property (p_start) else $error("start write did not convert");
  property p_init; ana_init |-> ana_busy; endproperty
  a_init: assert property (p_init) else $error("init outside conversion");
  property p_chan; s_busy3 |-> $stable(ana_pos_sel) && $stable(ana_neg_sel); endproperty
  a_chan: assert property (p_chan) else $error("channel moved mid conversion");
  property p_ref; s_busy3 |-> $stable(ana_ref_sel) && $stable(ana_bipolar); endproperty
  a_ref: assert property (p_ref) else $error("reference moved mid conversion");
  property p_power; reg_wr && reg_addr == 8'h06 && reg_wdata[7] |=> ana_power; endproperty
  a_power: assert property (p_power) else $error("power does not follow enable");
  property p_power_off; reg_wr && reg_addr == 8'h06 && !reg_wdata[7] |=> !ana_power; endproperty
  a_power_off: assert property (p_power_off) else $error("power kept after disable");
  property p_abort; $fell(ana_power) |-> ##[0:2] !ana_busy; endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted");
endmodule

bind adcr_top adcr_top_asserts i_chk (.*);

// file: dv/adcr_top_bench.sv
module adcr_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, irq_ack = 0, ana_negative = 0;
  logic global_irq_enable = 0, rd_q = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0;
  logic [6:1] trig_in = 0;
  logic [9:0] ana_value = 0;
  wire [7:0] reg_rdata;
  wire irq_req, ana_power, ana_busy, ana_init, ana_diff, ana_gain20, ana_offset_cal;
  wire ana_bipolar, ana_cmp_mux_en, ana_pol_rev;
  wire [2:0] ana_pos_sel, ana_neg_sel, ana_ref_sel;
  logic [7:0] expq[$];
  int n_mismatch = 0, checked = 0;
  adcr_top #(.DIV_W(7)) i_dut (.*);
  initial forever #4 mclk = ~mclk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge mclk) rd_q <= reg_rd;
  always @(negedge mclk) begin
    if (rd_q && expq.size() == 0) chk(1, 0);
    else if (rd_q) chk(reg_rdata, expq.pop_front());
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge mclk);
    reg_wr <= 0;
    reg_rd <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(0, a, 8'h00);
  endtask
  function automatic logic [9:0] res(input logic [3:0] c, input logic b, input logic ng,
                                     input logic [9:0] v);
    if (c < 4'h4 || c > 4'hb) return v;
    if (!b) return ng ? 10'h3ff : v;
    return ng ? -{1'b0, v[9:1]} : {1'b0, v[9:1]};
  endfunction
  function automatic logic [8:0] sel(input logic [3:0] c);
    logic [2:0] p, n;
    logic d;
    d = c >= 4'h4 && c <= 4'hb;
    p = c < 4'h4 ? c[2:0] : c == 4'hc ? 3'h5 : c == 4'hd ? 3'h6 : c == 4'hf ? 3'h4 : 3'h7;
    n = c[3] ? {2'b00, c[1]} : {2'b01, c[1]};
    if (d) p = c[3] ? 3'h0 : 3'h2;
    if (!d) n = 3'h7;
    return {p, n, d, d & c[0], d & !c[1]};
  endfunction
  // Window allows for the start latency and the divider phase
  task automatic waitc(input int len, input logic [8:0] sx);
    int n;
    n = 0;
    while (ana_busy !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk({ana_pos_sel, ana_neg_sel, ana_diff, ana_gain20, ana_offset_cal}, sx);
    chk(ana_init, len % 25 == 0);
    while (ana_busy !== 1'b0 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 4000) n_mismatch++;
    if (n >= 4000) wrap_up;
    chk(n >= len && n <= len + 6, 1);
  endtask
  task automatic run(input logic [7:0] a, input int len, input logic [8:0] sx);
    wr(8'h06, a);
    waitc(len, sx);
  endtask
  initial begin
    int i, len;
    logic [9:0] v, r;
    logic [3:0] ch;
    logic b, al, ng;
    v = $urandom(63534);
    repeat (2) @(posedge mclk);
    reset <= 0;
    for (i = 3; i < 9; i++) rd(i == 8 ? 8'h20 : 8'(i), 8'h00);
    wr(8'h07, 8'h01);
    run(8'hc0, 50, sel(4'h1));
    rd(8'h06, 8'h90);
    for (i = 0; i < 16; i++) begin
      ch = i;
      v = $urandom;
      b = $urandom;
      al = $urandom;
      ng = $urandom;
      ana_value <= v;
      ana_negative <= ng;
      wr(8'h03, {b, 7'h00});
      wr(8'h07, {2'b00, al, 1'b0, ch});
      len = 13 * (1 << (i % 8 > 1 ? i % 8 : 1));
      run(8'hd0 | 8'(i % 8), len, sel(ch));
      chk(ana_bipolar, b);
      r = res(ch, b, ng, v);
      rd(8'h04, al ? {r[1:0], 6'h00} : r[7:0]);
      rd(8'h05, al ? r[9:2] : {6'h00, r[9:8]});
      wr(8'h07, {2'b00, !al, 1'b0, ch});
      rd(8'h05, !al ? r[9:2] : {6'h00, r[9:8]});
    end
    wr(8'h07, 8'h00);
    rd(8'h04, r[7:0]);
    ana_value <= ~v;
    run(8'hd0, 26, sel(4'h0));
    rd(8'h05, {6'h00, r[9:8]});
    rd(8'h06, 8'h90);
    wr(8'h06, 8'hd0);
    wr(8'h07, 8'h25);
    rd(8'h05, r[9:2]);
    @(negedge mclk);
    chk({ana_pos_sel, ana_neg_sel, ana_diff, ana_gain20, ana_offset_cal}, sel(4'h0));
    wr(8'h06, 8'h00);
    repeat (3) @(negedge mclk);
    chk(ana_busy, 0);
    rd(8'h06, 8'h00);
    wr(8'h06, 8'h40);
    repeat (4) @(negedge mclk);
    chk(ana_busy, 0);
    rd(8'h06, 8'h00);
    @(posedge mclk) global_irq_enable <= 1;
    run(8'hc8, 50, sel(4'h5));
    repeat (2) @(negedge mclk);
    chk(irq_req, 1);
    @(posedge mclk) global_irq_enable <= 0;
    repeat (2) @(negedge mclk);
    chk(irq_req, 0);
    @(posedge mclk) global_irq_enable <= 1;
    @(posedge mclk) irq_ack <= 1;
    @(posedge mclk) irq_ack <= 0;
    @(negedge mclk);
    chk(irq_req, 0);
    rd(8'h06, 8'h88);
    run(8'hc8, 26, sel(4'h5));
    // A fresh full write clears the flag; no read-modify-write of control A
    wr(8'h06, 8'h98);
    rd(8'h06, 8'h88);
    wr(8'h07, 8'h40);
    run(8'hd0, 50, sel(4'h0));
    chk(ana_ref_sel, 3'h2);
    wr(8'h03, 8'h7b);
    rd(8'h03, 8'h63);
    @(negedge mclk);
    chk({ana_cmp_mux_en, ana_pol_rev}, 2'b11);
    wr(8'h06, 8'ha0);
    @(posedge mclk) trig_in[3] <= 1;
    waitc(30, sel(4'h0));
    rd(8'h06, 8'hb0);
    wr(8'h03, 8'h00);
    repeat (6) @(negedge mclk);
    chk(ana_busy, 0);
    chk({ana_cmp_mux_en, ana_pol_rev}, 2'b00);
    run(8'hf0, 26, sel(4'h0));
    waitc(26, sel(4'h0));
    wr(8'h06, 8'h00);
    wrap_up;
  end
endmodule
